// >>> hw/pdcms_pkg.sv
// constants, encodings and register layout of the power-down clock and module standby block
package pdcms_pkg;

    // ------------------------------------------------------------
    // register map
    // ------------------------------------------------------------
    localparam int           PDCMS_AW            = 8;
    localparam int           PDCMS_DW            = 8;
    localparam logic [7:0]   PDCMS_MODE_OFS      = 8'h00;
    localparam logic [7:0]   PDCMS_STBY_OFS      = 8'h01;

    // ------------------------------------------------------------
    // mode and clock select register fields
    // ------------------------------------------------------------
    localparam int           PDCMS_KIND_BIT      = 7;
    localparam int           PDCMS_DIRECT_BIT    = 5;
    localparam int           PDCMS_CSEL_HI       = 4;
    localparam int           PDCMS_CSEL_LO       = 2;
    localparam logic [7:0]   PDCMS_MODE_WMASK    = 8'hbc;
    localparam logic [7:0]   PDCMS_MODE_RESET    = 8'h00;

    // ------------------------------------------------------------
    // module standby register fields
    // ------------------------------------------------------------
    localparam int           PDCMS_NUM_UNITS     = 6;
    localparam int           PDCMS_STBY_FIRST    = 1;
    localparam int           PDCMS_WDT_IDX       = 2;
    localparam logic [7:0]   PDCMS_STBY_WMASK    = 8'h7e;
    localparam logic [7:0]   PDCMS_STBY_RESET    = 8'h00;

    // ------------------------------------------------------------
    // clock divider
    // ------------------------------------------------------------
    localparam int           PDCMS_DIV_W         = 6;
    localparam logic [2:0]   PDCMS_CSEL_RESET    = 3'h0;
    localparam logic [5:0]   PDCMS_LIM_DIV1      = 6'h00;
    localparam logic [5:0]   PDCMS_LIM_DIV8      = 6'h07;
    localparam logic [5:0]   PDCMS_LIM_DIV16     = 6'h0f;
    localparam logic [5:0]   PDCMS_LIM_DIV32     = 6'h1f;
    localparam logic [5:0]   PDCMS_LIM_DIV64     = 6'h3f;

    // ------------------------------------------------------------
    // operating modes
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        PDCMS_ACTIVE   = 2'b00,
        PDCMS_SLEEP    = 2'b01,
        PDCMS_SUBSLEEP = 2'b10,
        PDCMS_STANDBY  = 2'b11
    } pdcms_mode_t;

endpackage

// >>> hw/pdcms_clk_div.sv
// operating clock divider producing a one-cycle enable tick
`timescale 1ns/1ps
module pdcms_clk_div
    import pdcms_pkg::*;
(
    input  wire logic                   ref_clk,
    input  wire logic                   rstn,
    input  wire logic                   run,
    input  wire logic [2:0]             csel,
    output logic                        tick
);

    logic [PDCMS_DIV_W-1:0] cnt;
    logic [PDCMS_DIV_W-1:0] limit;
    logic                   at_limit;

    // ------------------------------------------------------------
    // divisor decode
    // ------------------------------------------------------------
    // top bit 0 means undivided, whatever the low bits hold
    assign limit = (csel[2] == 1'b0) ? PDCMS_LIM_DIV1 :
                   (csel[1:0] == 2'b00) ? PDCMS_LIM_DIV8 :
                   (csel[1:0] == 2'b01) ? PDCMS_LIM_DIV16 :
                   (csel[1:0] == 2'b10) ? PDCMS_LIM_DIV32 :
                   PDCMS_LIM_DIV64;

    assign at_limit = (cnt >= limit);
    assign tick     = run & at_limit;

    // ------------------------------------------------------------
    // counter
    // ------------------------------------------------------------
    // halted oscillator freezes the count so the phase resumes on wake
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            cnt <= '0;
        end else if (run) begin
            cnt <= at_limit ? '0 : cnt + 1'b1;
        end
    end

endmodule

// >>> hw/pdcms_mode_fsm.sv
// operating mode sequencer reacting to the sleep instruction and to interrupts
`timescale 1ns/1ps
module pdcms_mode_fsm
    import pdcms_pkg::*;
(
    input  wire logic                   ref_clk,
    input  wire logic                   rstn,
    input  wire logic                   sleep_exec,
    input  wire logic                   wake_irq,
    input  wire logic                   kind_sel,
    input  wire logic                   direct_flag,
    input  wire logic                   standby_sel,
    output pdcms_mode_t                 mode,
    output logic                        direct_done
);

    pdcms_mode_t next_mode;
    logic        go_direct;
    logic        next_direct_done;

    assign go_direct = direct_flag & ~kind_sel;

    // ------------------------------------------------------------
    // next mode
    // ------------------------------------------------------------
    always_comb begin
        next_mode        = mode;
        next_direct_done = 1'b0;
        case (mode)
            PDCMS_ACTIVE: begin
                if (sleep_exec) begin
                    if (go_direct) begin
                        next_direct_done = 1'b1;
                    end else if (standby_sel) begin
                        next_mode = PDCMS_STANDBY;
                    end else if (kind_sel) begin
                        next_mode = PDCMS_SUBSLEEP;
                    end else begin
                        next_mode = PDCMS_SLEEP;
                    end
                end
            end
            PDCMS_SLEEP, PDCMS_SUBSLEEP, PDCMS_STANDBY: begin
                if (wake_irq) begin
                    next_mode = PDCMS_ACTIVE;
                end
            end
            default: begin
                next_mode = PDCMS_ACTIVE;
            end
        endcase
    end

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            mode        <= PDCMS_ACTIVE;
            direct_done <= 1'b0;
        end else begin
            mode        <= next_mode;
            direct_done <= next_direct_done;
        end
    end

endmodule

// >>> hw/pdcms_top.sv
// power-down mode control, operating clock select and per-unit module standby
//
// Local design decisions: strobed register access and the register offsets.
`timescale 1ns/1ps
module pdcms_top
    import pdcms_pkg::*;
(
    input  wire logic                   ref_clk,
    input  wire logic                   rstn,
    input  wire logic [PDCMS_AW-1:0]    reg_addr,
    input  wire logic [PDCMS_DW-1:0]    reg_wdata,
    input  wire logic                   reg_wr,
    input  wire logic                   reg_rd,
    output logic      [PDCMS_DW-1:0]    reg_rdata,
    input  wire logic                   sleep_exec,
    input  wire logic                   wake_irq,
    input  wire logic                   standby_select,
    input  wire logic                   wdt_on_internal_osc,
    output logic      [1:0]             op_mode,
    output logic                        cpu_halt,
    output logic                        sys_osc_run,
    output logic                        direct_done,
    output logic                        op_clk_en,
    output logic      [2:0]             applied_clock_select,
    output logic                        two_wire_unit_clk_en,
    output logic                        serial_comm_unit_clk_en,
    output logic                        converter_clk_en,
    output logic                        watchdog_clk_en,
    output logic                        waveform_timer_clk_en,
    output logic                        event_timer_clk_en
);

    // ------------------------------------------------------------
    // register state
    // ------------------------------------------------------------
    logic [PDCMS_DW-1:0]        power_down_mode_and_clock_select;
    logic [PDCMS_DW-1:0]        peripheral_standby_control_one;
    logic [2:0]                 csel_applied;
    logic [PDCMS_DW-1:0]        next_rdata;
    pdcms_mode_t                mode;

    // ------------------------------------------------------------
    // decode
    // ------------------------------------------------------------
    logic                       hit_mode;
    logic                       hit_stby;
    logic                       wr_mode;
    logic                       wr_stby;
    logic                       sleep_kind_select;
    logic                       direct_transition_flag;
    logic [2:0]                 csel_written;
    logic [PDCMS_DW-1:0]        mode_rd_view;
    logic [PDCMS_DW-1:0]        stby_rd_view;

    assign hit_mode = (reg_addr == PDCMS_MODE_OFS);
    assign hit_stby = (reg_addr == PDCMS_STBY_OFS);
    assign wr_mode  = reg_wr & hit_mode;
    assign wr_stby  = reg_wr & hit_stby;

    assign sleep_kind_select      = power_down_mode_and_clock_select[PDCMS_KIND_BIT];
    assign direct_transition_flag = power_down_mode_and_clock_select[PDCMS_DIRECT_BIT];
    assign csel_written = power_down_mode_and_clock_select[PDCMS_CSEL_HI:PDCMS_CSEL_LO];

    // reserved bits are never stored, so masking on read is belt and braces
    assign mode_rd_view = power_down_mode_and_clock_select & PDCMS_MODE_WMASK;
    assign stby_rd_view = peripheral_standby_control_one & PDCMS_STBY_WMASK;

    assign next_rdata = !reg_rd  ? '0 :
                        hit_mode ? mode_rd_view :
                        hit_stby ? stby_rd_view :
                        '0;

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            power_down_mode_and_clock_select <= PDCMS_MODE_RESET;
        end else if (wr_mode) begin
            power_down_mode_and_clock_select <= reg_wdata & PDCMS_MODE_WMASK;
        end
    end

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            peripheral_standby_control_one <= PDCMS_STBY_RESET;
        end else if (wr_stby) begin
            peripheral_standby_control_one <= reg_wdata & PDCMS_STBY_WMASK;
        end
    end

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            reg_rdata <= '0;
        end else begin
            reg_rdata <= next_rdata;
        end
    end

    // ------------------------------------------------------------
    // clock select applied on the sleep instruction
    // ------------------------------------------------------------
    // software may rewrite the field freely; the divider only sees it here
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            csel_applied <= PDCMS_CSEL_RESET;
        end else if (sleep_exec && (mode == PDCMS_ACTIVE)) begin
            csel_applied <= csel_written;
        end
    end

    // ------------------------------------------------------------
    // mode sequencer
    // ------------------------------------------------------------
    pdcms_mode_fsm u_fsm (
        .ref_clk     (ref_clk),
        .rstn        (rstn),
        .sleep_exec  (sleep_exec),
        .wake_irq    (wake_irq),
        .kind_sel    (sleep_kind_select),
        .direct_flag (direct_transition_flag),
        .standby_sel (standby_select),
        .mode        (mode),
        .direct_done (direct_done)
    );

    logic osc_running;

    // oscillator halts in subsleep and standby
    assign osc_running = (mode == PDCMS_ACTIVE) | (mode == PDCMS_SLEEP);

    // ------------------------------------------------------------
    // operating clock divider
    // ------------------------------------------------------------
    logic div_tick;

    pdcms_clk_div u_div (
        .ref_clk (ref_clk),
        .rstn    (rstn),
        .run     (osc_running),
        .csel    (csel_applied),
        .tick    (div_tick)
    );

    // ------------------------------------------------------------
    // module standby gating
    // ------------------------------------------------------------
    // gating the enable, not the reset, keeps each unit's state intact
    logic [PDCMS_NUM_UNITS-1:0] unit_clk_en;

    genvar g;
    generate
        for (g = 0; g < PDCMS_NUM_UNITS; g++) begin : g_unit
            if (g == PDCMS_WDT_IDX) begin : g_wdt
                assign unit_clk_en[g] = wdt_on_internal_osc |
                    (div_tick & ~peripheral_standby_control_one[g+PDCMS_STBY_FIRST]);
            end else begin : g_std
                assign unit_clk_en[g] = div_tick &
                    ~peripheral_standby_control_one[g+PDCMS_STBY_FIRST];
            end
        end
    endgenerate

    assign event_timer_clk_en      = unit_clk_en[0];
    assign waveform_timer_clk_en   = unit_clk_en[1];
    assign watchdog_clk_en         = unit_clk_en[2];
    assign converter_clk_en        = unit_clk_en[3];
    assign serial_comm_unit_clk_en = unit_clk_en[4];
    assign two_wire_unit_clk_en    = unit_clk_en[5];

    // ------------------------------------------------------------
    // status outputs
    // ------------------------------------------------------------
    assign op_mode              = mode;
    assign cpu_halt             = (mode != PDCMS_ACTIVE);
    assign sys_osc_run          = osc_running;
    assign op_clk_en            = div_tick;
    assign applied_clock_select = csel_applied;

endmodule

// >>> verification/pdcms_assertions.sv
// assertion checker for the power-down clock and module standby block
`timescale 1ns/1ps
module pdcms_assertions
    import pdcms_pkg::*;
(
    input wire logic       ref_clk,
    input wire logic       rstn,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic       reg_wr,
    input wire logic       reg_rd,
    input wire logic [7:0] reg_rdata,
    input wire logic       sleep_exec,
    input wire logic       wake_irq,
    input wire logic       standby_select,
    input wire logic       wdt_on_internal_osc,
    input wire logic [1:0] op_mode,
    input wire logic       cpu_halt,
    input wire logic       sys_osc_run,
    input wire logic       direct_done,
    input wire logic       op_clk_en,
    input wire logic [2:0] applied_clock_select,
    input wire logic       two_wire_unit_clk_en,
    input wire logic       watchdog_clk_en,
    input wire logic       event_timer_clk_en
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rstn);
    // ----
    // sequences
    // ----
    sequence s_sleep_req; op_mode == 2'b00 && sleep_exec; endsequence
    sequence s_tick16; applied_clock_select == 3'b101 && op_clk_en && op_mode == 2'b00 && !sleep_exec; endsequence
    sequence s_quiet8; !op_clk_en [*8]; endsequence
    sequence s_stby_wr; reg_wr && reg_addr == PDCMS_STBY_OFS; endsequence
    // ----
    // properties
    // ----
    property p_rd_mode; reg_rd && reg_addr == PDCMS_MODE_OFS |=> (reg_rdata & 8'h43) == 8'h00; endproperty
    a_rd_mode: assert property (p_rd_mode) else $error("mode reserved bits nonzero");
    property p_rd_stby; reg_rd && reg_addr == PDCMS_STBY_OFS |=> (reg_rdata & 8'h81) == 8'h00; endproperty
    a_rd_stby: assert property (p_rd_stby) else $error("standby reserved bits nonzero");
    // the select may move only on a sleep taken in active mode
    property p_hold_sel; $changed(applied_clock_select) |-> $past(sleep_exec) && $past(op_mode) == 2'b00; endproperty
    a_hold_sel: assert property (p_hold_sel) else $error("clock select applied early");
    property p_standby; s_sleep_req ##0 standby_select |=> op_mode == 2'b11 || direct_done; endproperty
    a_standby: assert property (p_standby) else $error("standby not entered");
    property p_wake; op_mode != 2'b00 && wake_irq |=> op_mode == 2'b00 && !cpu_halt && sys_osc_run; endproperty
    a_wake: assert property (p_wake) else $error("wake did not reach active");
    property p_direct; direct_done |-> op_mode == 2'b00 && $past(sleep_exec); endproperty
    a_direct: assert property (p_direct) else $error("direct pulse without sleep");
    property p_div16; s_tick16 |=> s_quiet8; endproperty
    a_div16: assert property (p_div16) else $error("divide by 16 ticks too soon");
    property p_wdt; wdt_on_internal_osc |-> watchdog_clk_en; endproperty
    a_wdt: assert property (p_wdt) else $error("watchdog gated on internal osc");
    property p_gate_tw; s_stby_wr ##0 reg_wdata[6] |=> !two_wire_unit_clk_en; endproperty
    a_gate_tw: assert property (p_gate_tw) else $error("two-wire unit not gated");
    property p_gate_ev; s_stby_wr ##0 reg_wdata[1] |=> !event_timer_clk_en; endproperty
    a_gate_ev: assert property (p_gate_ev) else $error("event timer not gated");
endmodule

bind pdcms_top pdcms_assertions u_chk (.*);

// >>> verification/pdcms_units.sv
// behavioural model of the peripheral units fed by the per-unit clock enables
`timescale 1ns/1ps
module pdcms_units
(
    input  wire logic             ref_clk,
    input  wire logic             rstn,
    input  wire logic [5:0]       clk_en,
    output logic      [5:0][15:0] ticks
);
    // a gated unit keeps its state; nothing here clears it, so a restore shows as a resumed count
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            ticks <= '0;
        end else begin
            for (int i = 0; i < 6; i++) begin
                if (clk_en[i]) begin
                    ticks[i] <= ticks[i] + 16'h0001;
                end
            end
        end
    end
endmodule

// >>> verification/pdcms_tb_top.sv
// self-checking bench for the power-down clock and module standby block
`timescale 1ns/1ps
module pdcms_tb_top
    import pdcms_pkg::*;
;
    logic             ref_clk, rstn, reg_wr, reg_rd, sleep_exec, wake_irq, standby_select, wdt_on_internal_osc;
    logic [7:0]       reg_addr, reg_wdata, reg_rdata, v, got;
    logic [1:0]       op_mode;
    logic             cpu_halt, sys_osc_run, direct_done, op_clk_en;
    logic [2:0]       applied_clock_select;
    wire  [5:0]       en;
    logic [5:0][15:0] ticks;
    logic [15:0]      t0;
    int               failures, total_checks, cycles, seed;
    logic [7:0]       mreg [5] = '{8'h00, 8'h80, 8'h00, 8'h20, 8'h80};
    logic             ssel [5] = '{1'b0, 1'b0, 1'b1, 1'b1, 1'b1};
    logic [1:0]       mexp [5] = '{2'b01, 2'b10, 2'b11, 2'b00, 2'b11};

    pdcms_top uut (.ref_clk(ref_clk), .rstn(rstn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .sleep_exec(sleep_exec),
        .wake_irq(wake_irq), .standby_select(standby_select), .wdt_on_internal_osc(wdt_on_internal_osc),
        .op_mode(op_mode), .cpu_halt(cpu_halt), .sys_osc_run(sys_osc_run), .direct_done(direct_done),
        .op_clk_en(op_clk_en), .applied_clock_select(applied_clock_select),
        .two_wire_unit_clk_en(en[5]), .serial_comm_unit_clk_en(en[4]), .converter_clk_en(en[3]),
        .watchdog_clk_en(en[2]), .waveform_timer_clk_en(en[1]), .event_timer_clk_en(en[0]));
    pdcms_units u_units (.ref_clk(ref_clk), .rstn(rstn), .clk_en(en), .ticks(ticks));

    // ----
    // expectations and checks
    // ----
    function automatic logic [5:0] exp_en(input logic [7:0] s, input logic w);
        exp_en = ~s[6:1];
        exp_en[2] = exp_en[2] | w;
    endfunction
    task automatic chk(input logic [7:0] g, input logic [7:0] e);
        total_checks++;
        if (g !== e) begin
            failures++;
            $display("wrong value at %0t: got %h expected %h", $time, g, e);
        end
    endtask
    task automatic chk_cnt(input logic [15:0] g, input logic [15:0] e);
        total_checks++;
        if (g !== e) begin
            failures++;
            $display("wrong value at %0t: tick count %0d expected %0d", $time, g, e);
        end
    endtask
    task automatic give_verdict();
        $display("checks %0d failures %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    // ----
    // bus and event drivers
    // ----
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
        #1;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge ref_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        #1 d = reg_rdata;
    endtask
    task automatic act(input logic s, input logic w);
        @(posedge ref_clk);
        sleep_exec <= s;
        wake_irq <= w;
        @(posedge ref_clk);
        sleep_exec <= 1'b0;
        wake_irq <= 1'b0;
        #1;
    endtask

    initial begin
        ref_clk = 1'b0;
        forever #25 ref_clk = ~ref_clk;
    end
    // a hang is cut short well past the fewer than a thousand cycles the run needs
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 4000) begin
            failures++;
            $display("wrong value at %0t: run did not finish", $time);
            give_verdict();
        end
    end

    initial begin
        {rstn, reg_wr, reg_rd, sleep_exec, wake_irq, standby_select, wdt_on_internal_osc} = '0;
        {reg_addr, reg_wdata} = '0;
        seed = 95043;
        repeat (6) @(posedge ref_clk);
        rstn <= 1'b1;
        rd(PDCMS_MODE_OFS, got);
        chk(got, 8'h00);
        rd(PDCMS_STBY_OFS, got);
        chk(got, 8'h00);
        chk({2'b00, en}, 8'h3f);
        // one-hot standby corners first, then random traffic on both registers
        for (int i = 0; i < 22; i++) begin
            v = (i < 6) ? (8'h02 << i) : 8'($random(seed));
            wdt_on_internal_osc <= (i < 6) ? 1'b0 : 1'($random(seed));
            wr((i < 6) ? PDCMS_STBY_OFS : {7'h00, i[0]}, v);
            rd((i < 6) ? PDCMS_STBY_OFS : {7'h00, i[0]}, got);
            chk(got, v & (i[0] || i < 6 ? PDCMS_STBY_WMASK : PDCMS_MODE_WMASK));
            if (i < 6 || i[0]) begin
                chk({2'b00, en}, {2'b00, exp_en(v, wdt_on_internal_osc)});
            end
            chk({5'h00, applied_clock_select}, 8'h00);
        end
        wr(8'h02, 8'hff);
        rd(8'h02, got);
        chk(got, 8'h00);
        // gated unit resumes its count without losing state
        wdt_on_internal_osc <= 1'b0;
        wr(PDCMS_STBY_OFS, 8'h02);
        t0 = ticks[0];
        repeat (10) @(posedge ref_clk);
        #1 chk_cnt(ticks[0] - t0, 16'h0000);
        wr(PDCMS_STBY_OFS, 8'h00);
        t0 = ticks[0];
        repeat (10) @(posedge ref_clk);
        #1 chk_cnt(ticks[0] - t0, 16'h000a);
        // clock select codes in rising order, switched by direct transitions
        for (int c = 3; c < 8; c++) begin
            wr(PDCMS_MODE_OFS, {3'b001, 3'(c), 2'b00});
            chk({5'h00, applied_clock_select}, {5'h00, 3'((c == 3) ? 0 : c - 1)});
            act(1'b1, 1'b0);
            chk({5'h00, direct_done, op_mode}, 8'h04);
            chk({5'h00, applied_clock_select}, {5'h00, 3'(c)});
            t0 = ticks[0];
            repeat (128) @(posedge ref_clk);
            #1 chk_cnt(ticks[0] - t0, 16'(128 >> (c > 3 ? c - 1 : 0)));
        end
        // every sleep entry path, a refused second sleep, then wake
        act(1'b0, 1'b1);
        chk({6'h00, op_mode}, 8'h00);
        for (int k = 0; k < 5; k++) begin
            wr(PDCMS_MODE_OFS, mreg[k]);
            standby_select <= ssel[k];
            act(1'b1, 1'b0);
            chk({4'h0, cpu_halt, sys_osc_run, op_mode}, {4'h0, mexp[k] != 0, mexp[k] < 2, mexp[k]});
            act(1'b1, 1'b0);
            chk({6'h00, op_mode}, {6'h00, mexp[k]});
            act(1'b0, 1'b1);
            chk({6'h00, op_mode}, 8'h00);
        end
        // a reset in mid-run must clear the stored mode bits and the applied select
        rstn <= 1'b0;
        repeat (2) @(posedge ref_clk);
        rstn <= 1'b1;
        rd(PDCMS_MODE_OFS, got);
        chk(got, 8'h00);
        chk({5'h00, applied_clock_select}, 8'h00);
        give_verdict();
    end
endmodule
